// File: hdl/rcp_pkg.sv
// shared widths, reset values, counts and states of the command register
package rcp_pkg;
    // widths of the command/address bus on both sides, and the number of output clock pairs
    localparam int ADDR_W = 16;
    localparam int BANK_W = 3;
    localparam int CKE_W = 2;
    localparam int ODT_W = 2;
    localparam int RANK_W = 4;
    localparam int DUAL_RANK_W = 2;
    localparam int CLK_PAIRS = 4;

    // clock period, kept for derived counts
    localparam int CLK_PERIOD_NS = 20;

    // cycles the strap synchroniser needs before the strap is trusted
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;
    // cycles the fault output stays low after one mismatch
    localparam logic [1:0] FAULT_HOLD_CYCLES = 2'h2;

    // values after reset
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [BANK_W-1:0] BANK_RST = 3'h0;
    localparam logic STROBE_N_RST = 1'h1;
    localparam logic [CKE_W-1:0] CKE_RST = 2'h0;
    localparam logic [ODT_W-1:0] ODT_RST = 2'h0;
    localparam logic [DUAL_RANK_W-1:0] DUAL_RANK_N_RST = 2'h3;
    localparam logic [RANK_W-1:0] QUAD_RANK_N_RST = 4'hF;
    localparam logic [1:0] HOLD_RST = 2'h0;

    // bring-up sequence, gray coded along settle -> run
    typedef enum logic [1:0] {
        RCP_ST_IDLE = 2'b00,
        RCP_ST_SETTLE = 2'b01,
        RCP_ST_RUN = 2'b11
    } rcp_state_e;
endpackage

// File: hdl/rcp_cmd_register.sv
`timescale 1ns/1ps
`default_nettype none

module rcp_cmd_register (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic quad_select_strap_n,
    input wire logic [rcp_pkg::ADDR_W-1:0] addr_in,
    input wire logic [rcp_pkg::BANK_W-1:0] bank_addr_in,
    input wire logic row_strobe_in_n,
    input wire logic col_strobe_in_n,
    input wire logic write_en_in_n,
    input wire logic [rcp_pkg::CKE_W-1:0] clk_en_in,
    input wire logic [rcp_pkg::ODT_W-1:0] term_ctrl_in,
    input wire logic [rcp_pkg::RANK_W-1:0] rank_select_in_n,
    input wire logic parity_bit_in,
    output logic [rcp_pkg::ADDR_W-1:0] addr_a_out,
    output logic [rcp_pkg::ADDR_W-1:0] addr_b_out,
    output logic [rcp_pkg::BANK_W-1:0] bank_addr_a_out,
    output logic [rcp_pkg::BANK_W-1:0] bank_addr_b_out,
    output logic row_strobe_a_n_out,
    output logic row_strobe_b_n_out,
    output logic col_strobe_a_n_out,
    output logic col_strobe_b_n_out,
    output logic write_en_a_n_out,
    output logic write_en_b_n_out,
    output logic [rcp_pkg::CKE_W-1:0] clk_en_out_a,
    output logic [rcp_pkg::CKE_W-1:0] clk_en_out_b,
    output logic [rcp_pkg::ODT_W-1:0] term_ctrl_out_a,
    output logic [rcp_pkg::ODT_W-1:0] term_ctrl_out_b,
    output logic [rcp_pkg::DUAL_RANK_W-1:0] rank_select_out_side_a_n,
    output logic [rcp_pkg::DUAL_RANK_W-1:0] rank_select_out_side_b_n,
    output logic [rcp_pkg::RANK_W-1:0] rank_select_out_quad_n,
    output logic four_rank_select_mode_out,
    output logic cmd_drive_en_out,
    output logic parity_fault_out_n,
    output logic parity_fault_oe_n_out,
    output logic [rcp_pkg::CLK_PAIRS-1:0] dram_clk_out,
    output logic [rcp_pkg::CLK_PAIRS-1:0] dram_clk_out_n,
    output logic feedback_clk_out,
    output logic feedback_clk_out_n
);
    import rcp_pkg::*;

    // true when exactly one active-low select is asserted
    function automatic logic one_select_low(input logic [RANK_W-1:0] sel_n, input logic quad);
        logic [2:0] cnt;
        cnt = 3'h0;
        for (int i = 0; i < RANK_W; i++) begin
            if ((quad || i < DUAL_RANK_W) && !sel_n[i]) begin
                cnt = cnt + 3'h1;
            end
        end
        return (cnt == 3'h1);
    endfunction

    // xor of all checked bits and the parity bit; one means odd count
    function automatic logic odd_ones(
        input logic [ADDR_W-1:0] a,
        input logic [BANK_W-1:0] ba,
        input logic ras_n,
        input logic cas_n,
        input logic we_n,
        input logic par
    );
        return ^{a, ba, ras_n, cas_n, we_n, par};
    endfunction

    logic strap_meta;
    logic strap_sync;
    rcp_state_e state;
    rcp_state_e next_state;
    logic [1:0] settle_cnt;
    logic four_rank_select_mode;
    logic running;
    logic sel_ok;
    logic parity_bad;
    logic [1:0] fault_hold;
    logic [RANK_W-1:0] live_sel_n;

    // strap comes from a board pin: two flops before anyone looks at it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            strap_meta <= 1'b1;
            strap_sync <= 1'b1;
        end else begin
            strap_meta <= quad_select_strap_n;
            strap_sync <= strap_meta;
        end
    end

    // bring-up sequencing after reset release
    always_comb begin
        next_state = state;
        case (state)
            RCP_ST_IDLE: begin
                next_state = RCP_ST_SETTLE;
            end
            RCP_ST_SETTLE: begin
                if (settle_cnt == SETTLE_CYCLES) begin
                    next_state = RCP_ST_RUN;
                end
            end
            RCP_ST_RUN: begin
                next_state = RCP_ST_RUN;
            end
            default: begin
                next_state = RCP_ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= RCP_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // waits out the synchroniser so a stale strap is never latched
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            settle_cnt <= 2'h0;
        end else if (state == RCP_ST_SETTLE && settle_cnt != SETTLE_CYCLES) begin
            settle_cnt <= settle_cnt + 2'h1;
        end
    end

    // strap latched once at the end of settle; later changes are ignored
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            four_rank_select_mode <= 1'b0;
        end else if (state == RCP_ST_SETTLE && next_state == RCP_ST_RUN) begin
            four_rank_select_mode <= ~strap_sync;
        end
    end

    assign running = (state == RCP_ST_RUN);
    assign four_rank_select_mode_out = four_rank_select_mode;

    // in two-select mode the upper select inputs are treated as idle
    assign live_sel_n = four_rank_select_mode ? rank_select_in_n
                                              : {2'h3, rank_select_in_n[DUAL_RANK_W-1:0]};
    assign sel_ok = running && one_select_low(rank_select_in_n, four_rank_select_mode);

    // command and address, duplicated to both sides in either mode
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_a_out <= ADDR_RST;
            addr_b_out <= ADDR_RST;
            bank_addr_a_out <= BANK_RST;
            bank_addr_b_out <= BANK_RST;
            row_strobe_a_n_out <= STROBE_N_RST;
            row_strobe_b_n_out <= STROBE_N_RST;
            col_strobe_a_n_out <= STROBE_N_RST;
            col_strobe_b_n_out <= STROBE_N_RST;
            write_en_a_n_out <= STROBE_N_RST;
            write_en_b_n_out <= STROBE_N_RST;
        end else if (sel_ok) begin
            addr_a_out <= addr_in;
            addr_b_out <= addr_in;
            bank_addr_a_out <= bank_addr_in;
            bank_addr_b_out <= bank_addr_in;
            row_strobe_a_n_out <= row_strobe_in_n;
            row_strobe_b_n_out <= row_strobe_in_n;
            col_strobe_a_n_out <= col_strobe_in_n;
            col_strobe_b_n_out <= col_strobe_in_n;
            write_en_a_n_out <= write_en_in_n;
            write_en_b_n_out <= write_en_in_n;
        end
        // otherwise the last forwarded command stays put
    end

    // rank-dependent controls follow every cycle in run so power-down works idle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            clk_en_out_a <= CKE_RST;
            clk_en_out_b <= CKE_RST;
            term_ctrl_out_a <= ODT_RST;
            term_ctrl_out_b <= ODT_RST;
        end else if (running) begin
            clk_en_out_a <= clk_en_in;
            clk_en_out_b <= clk_en_in;
            term_ctrl_out_a <= term_ctrl_in;
            term_ctrl_out_b <= term_ctrl_in;
        end
    end

    // selects: forwarded with a valid command, otherwise all deselected
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rank_select_out_side_a_n <= DUAL_RANK_N_RST;
            rank_select_out_side_b_n <= DUAL_RANK_N_RST;
            rank_select_out_quad_n <= QUAD_RANK_N_RST;
        end else if (!sel_ok) begin
            rank_select_out_side_a_n <= DUAL_RANK_N_RST;
            rank_select_out_side_b_n <= DUAL_RANK_N_RST;
            rank_select_out_quad_n <= QUAD_RANK_N_RST;
        end else if (four_rank_select_mode) begin
            rank_select_out_side_a_n <= DUAL_RANK_N_RST;
            rank_select_out_side_b_n <= DUAL_RANK_N_RST;
            rank_select_out_quad_n <= live_sel_n;
        end else begin
            rank_select_out_side_a_n <= live_sel_n[DUAL_RANK_W-1:0];
            rank_select_out_side_b_n <= live_sel_n[DUAL_RANK_W-1:0];
            rank_select_out_quad_n <= QUAD_RANK_N_RST;
        end
    end

    // even parity: the selects, clock enables and termination stay out
    assign parity_bad = sel_ok && odd_ones(addr_in, bank_addr_in, row_strobe_in_n,
                                           col_strobe_in_n, write_en_in_n,
                                           parity_bit_in);

    // a fresh mismatch restarts the hold, so back-to-back errors merge
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fault_hold <= HOLD_RST;
        end else if (parity_bad) begin
            fault_hold <= FAULT_HOLD_CYCLES;
        end else if (fault_hold != HOLD_RST) begin
            fault_hold <= fault_hold - 2'h1;
        end
    end

    // open drain: pull low while a fault is held, else release the pin
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            parity_fault_oe_n_out <= 1'b1;
        end else begin
            parity_fault_oe_n_out <= !(parity_bad || fault_hold > 2'h1);
        end
    end
    assign parity_fault_out_n = 1'b0; // level driven when enabled

    // command drivers stay off until the strap is latched, limits glitches
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_drive_en_out <= 1'b0;
        end else begin
            cmd_drive_en_out <= (next_state == RCP_ST_RUN);
        end
    end

    // clock fan-out; gated by cmd_drive_en_out here, the loop itself is analog
    assign dram_clk_out = {CLK_PAIRS{clk_in & cmd_drive_en_out}};
    assign dram_clk_out_n = {CLK_PAIRS{~clk_in & cmd_drive_en_out}};
    assign feedback_clk_out = clk_in & cmd_drive_en_out;
    assign feedback_clk_out_n = ~clk_in & cmd_drive_en_out;

endmodule

`default_nettype wire

// File: hdl/unused_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: verif/rcp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller side: one command per call, lines held at defined levels
module rcp_ctrl_model (
    input wire logic clk_in,
    output logic [rcp_pkg::ADDR_W-1:0] addr_out,
    output logic [rcp_pkg::BANK_W-1:0] bank_out,
    output logic [2:0] strobe_n_out,
    output logic [rcp_pkg::RANK_W-1:0] sel_n_out,
    output logic [1:0] cke_out,
    output logic [1:0] odt_out,
    output logic par_out
);
    import rcp_pkg::*;
    // never floating, so parity is always computable
    initial begin
        addr_out = 16'h0000;
        bank_out = 3'h0;
        strobe_n_out = 3'h7;
        sel_n_out = 4'hF;
        cke_out = 2'h0;
        odt_out = 2'h0;
        par_out = 1'b1;
    end
    // bank, strobes and rank controls are carved from the address word
    task automatic send(input logic [15:0] a, input logic [3:0] s, input logic bad);
        addr_out = a;
        bank_out = a[15:13];
        strobe_n_out = a[6:4];
        cke_out = a[1:0];
        odt_out = a[3:2];
        sel_n_out = s;
        par_out = ^{a, a[15:13], a[6:4]} ^ bad;
        @(posedge clk_in);
        #1;
    endtask
endmodule
`default_nettype wire

// File: verif/rcp_cmd_register_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rcp_cmd_register_sva (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [rcp_pkg::ADDR_W-1:0] addr_in,
    input wire logic [rcp_pkg::BANK_W-1:0] bank_addr_in,
    input wire logic row_strobe_in_n,
    input wire logic col_strobe_in_n,
    input wire logic write_en_in_n,
    input wire logic [rcp_pkg::RANK_W-1:0] rank_select_in_n,
    input wire logic parity_bit_in,
    input wire logic [rcp_pkg::ADDR_W-1:0] addr_a_out,
    input wire logic [rcp_pkg::DUAL_RANK_W-1:0] rank_select_out_side_a_n,
    input wire logic [rcp_pkg::RANK_W-1:0] rank_select_out_quad_n,
    input wire logic four_rank_select_mode_out,
    input wire logic cmd_drive_en_out,
    input wire logic parity_fault_oe_n_out
);
    import rcp_pkg::*;
    logic [3:0] live;
    logic take;
    logic bad;
    // upper selects only count in four-select mode
    assign live = four_rank_select_mode_out ? ~rank_select_in_n : {2'h0, ~rank_select_in_n[1:0]};
    assign take = cmd_drive_en_out && $onehot(live);
    assign bad = take && ^{addr_in, bank_addr_in, row_strobe_in_n, col_strobe_in_n,
        write_en_in_n, parity_bit_in};
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_addr_take: assert property (take |=> addr_a_out == $past(addr_in))
        else $error("address not forwarded");
    a_addr_hold: assert property (cmd_drive_en_out && !take |=> $stable(addr_a_out))
        else $error("address changed without command");
    a_sel_release: assert property (cmd_drive_en_out && !take |=>
        &rank_select_out_quad_n)
        else $error("select driven without command");
    a_quad_map: assert property (take && four_rank_select_mode_out |=>
        rank_select_out_quad_n == $past(rank_select_in_n))
        else $error("quad select mismatch");
    a_dual_map: assert property (take && !four_rank_select_mode_out |=>
        {2'h3, rank_select_out_side_a_n} == ($past(rank_select_in_n) | 4'hC))
        else $error("dual select mismatch");
    a_fault_set: assert property (bad |=> !parity_fault_oe_n_out [*2])
        else $error("parity fault not flagged");
    a_fault_clear: assert property (!bad [*2] |=> parity_fault_oe_n_out)
        else $error("parity fault without cause");
    a_reset_quiet: assert property (disable iff (1'b0) rst_in |->
        !cmd_drive_en_out && parity_fault_oe_n_out)
        else $error("outputs active in reset");
    // main scenarios reached
    c_fault: cover property (bad);
    c_quad: cover property (take && four_rank_select_mode_out);
    c_refused: cover property (cmd_drive_en_out && !take);
endmodule
bind rcp_cmd_register rcp_cmd_register_sva chk (.*);
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rcp_pkg::*;
    typedef struct {logic [3:0] sel; logic [15:0] a; logic bad; logic [15:0] ea;
        logic [1:0] es; logic ef;} rcp_row_s;
    logic clk_in = 1'b0;
    logic rst_in = 1'b0;
    logic strap_n = 1'b1;
    logic [15:0] addr, addr_a, addr_b;
    logic [2:0] bank, bank_a, strb;
    logic [2:0] bank_b, strb_a, strb_b;
    logic [1:0] cke_b, odt_b;
    logic [3:0] dclk_n;
    logic fault_lvl, fb_clk_n;
    logic [3:0] sel_n, quad_n, dclk, q;
    logic [1:0] cke, cke_a, odt, odt_a, side_a, side_b;
    logic par, mode, drv_en, fault_oe_n, fb_clk;
    int fail_count = 0;
    int comparisons = 0;
    // back to back: accepted, bad parity, refused (none, two, upper only), upper ignored
    rcp_row_s rows[6] = '{'{4'hE, 16'h1234, 1'b0, 16'h1234, 2'h2, 1'b1},
        '{4'hD, 16'hA5A5, 1'b1, 16'hA5A5, 2'h1, 1'b0}, '{4'hF, 16'hFFFF, 1'b1, 16'hA5A5, 2'h3, 1'b0},
        '{4'hC, 16'h0F0F, 1'b0, 16'hA5A5, 2'h3, 1'b1}, '{4'h3, 16'h1111, 1'b0, 16'hA5A5, 2'h3, 1'b1},
        '{4'h2, 16'h8001, 1'b0, 16'h8001, 2'h2, 1'b1}};
    rcp_ctrl_model model (.clk_in(clk_in), .addr_out(addr), .bank_out(bank), .strobe_n_out(strb),
        .sel_n_out(sel_n), .cke_out(cke), .odt_out(odt), .par_out(par));
    rcp_cmd_register dut (.clk_in(clk_in), .rst_in(rst_in), .quad_select_strap_n(strap_n),
        .addr_in(addr), .bank_addr_in(bank), .row_strobe_in_n(strb[2]), .col_strobe_in_n(strb[1]),
        .write_en_in_n(strb[0]), .clk_en_in(cke), .term_ctrl_in(odt), .rank_select_in_n(sel_n),
        .parity_bit_in(par), .addr_a_out(addr_a), .addr_b_out(addr_b), .bank_addr_a_out(bank_a),
        .bank_addr_b_out(bank_b), .row_strobe_a_n_out(strb_a[2]), .row_strobe_b_n_out(strb_b[2]),
        .col_strobe_a_n_out(strb_a[1]), .col_strobe_b_n_out(strb_b[1]),
        .write_en_a_n_out(strb_a[0]), .write_en_b_n_out(strb_b[0]), .clk_en_out_a(cke_a),
        .clk_en_out_b(cke_b), .term_ctrl_out_a(odt_a), .term_ctrl_out_b(odt_b),
        .rank_select_out_side_a_n(side_a), .rank_select_out_side_b_n(side_b),
        .rank_select_out_quad_n(quad_n), .four_rank_select_mode_out(mode),
        .cmd_drive_en_out(drv_en), .parity_fault_out_n(fault_lvl),
        .parity_fault_oe_n_out(fault_oe_n), .dram_clk_out(dclk), .dram_clk_out_n(dclk_n),
        .feedback_clk_out(fb_clk), .feedback_clk_out_n(fb_clk_n));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // reset, check quiet outputs, then wait out the bring-up
    task automatic start(input logic strap);
        rst_in = 1'b1;
        strap_n = strap;
        repeat (8) @(posedge clk_in);
        #1;
        check("drive_en", drv_en, 1'b0);
        check("fault_rst", fault_oe_n, 1'b1);
        check("addr_rst", addr_a, 16'h0000);
        check("clk_rst", dclk, 4'h0);
        rst_in = 1'b0;
        repeat (5) @(posedge clk_in);
        #1;
        check("mode", mode, !strap);
        check("dram_clk", {fb_clk, dclk}, 5'h1F);
        check("dram_clk_n", {fb_clk_n, dclk_n}, 5'h00);
        $display("reset test done");
    endtask
    // 50 MHz clock
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    // run is under 60 cycles, far below this limit
    initial begin
        #100000;
        fail_count++;
        $display("watchdog expired");
        tally_and_finish();
    end
    // main sequence
    initial begin
        #1;
        start(1'b1);
        foreach (rows[i]) begin
            model.send(rows[i].a, rows[i].sel, rows[i].bad);
            check("addr_a", addr_a, rows[i].ea);
            check("addr_b", addr_b, rows[i].ea);
            check("bank_a", bank_a, rows[i].ea[15:13]);
            check("bank_b", bank_b, rows[i].ea[15:13]);
            check("strb_a", strb_a, rows[i].ea[6:4]);
            check("strb_b", strb_b, rows[i].ea[6:4]);
            check("side_a", side_a, rows[i].es);
            check("side_b", side_b, rows[i].es);
            check("quad_idle", quad_n, 4'hF);
            check("fault", fault_oe_n, rows[i].ef);
            check("fault_lvl", fault_lvl, 1'b0);
            check("cke", {odt_a, cke_a}, rows[i].a[3:0]);
            check("cke_b", {odt_b, cke_b}, rows[i].a[3:0]);
        end
        $display("two-select test done");
        start(1'b0);
        for (int i = 0; i < 4; i++) begin
            q = ~(4'h1 << i);
            model.send(16'h0100 << i, q, 1'b0);
            check("quad", quad_n, q);
            check("quad_addr", addr_a, 16'h0100 << i);
            check("side_idle", {side_b, side_a}, 4'hF);
        end
        model.send(16'h0040, 4'hA, 1'b1);
        check("quad_two", quad_n, 4'hF);
        check("fault_two", fault_oe_n, 1'b1);
        model.send(16'h0200, 4'h7, 1'b1);
        check("fault_c1", fault_oe_n, 1'b0);
        model.send(16'h0200, 4'hF, 1'b0);
        check("fault_c2", fault_oe_n, 1'b0);
        model.send(16'h0200, 4'hF, 1'b0);
        check("fault_c3", fault_oe_n, 1'b1);
        $display("four-select test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
